// *** qos_pkg.sv ***
package qos_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int ADDR_W = 7;
	localparam int LEN_W = 11;
	localparam int LIMIT_W = 12;
	localparam int COUNT_W = 24;
	localparam int NUM_LIMITS = 4;

	// ----------------------------------------------------------------
	// global registers
	// ----------------------------------------------------------------
	localparam logic [6:0] BASE_PRI_ADDR = 7'h02;
	localparam int BASE_PRI_LSB = 4;
	localparam logic [2:0] BASE_PRI_RESET = 3'h4;
	localparam logic [6:0] SCHEME_ADDR = 7'h05;
	localparam int SCHEME_LSB = 2;
	localparam logic [6:0] MAP_FIRST_ADDR = 7'h60;
	localparam logic [6:0] MAP_LAST_ADDR = 7'h67;
	localparam int MAP_REGS = 8;

	// ----------------------------------------------------------------
	// per port registers
	// ----------------------------------------------------------------
	localparam logic [6:0] PORT_BASE = 7'h10;
	localparam logic [6:0] PORT_STRIDE = 7'h10;
	localparam logic [6:0] CTRL0_OFS = 7'h00;
	localparam logic [6:0] LIMIT_OFS = 7'h05;
	localparam logic [6:0] STATUS_OFS = 7'h0f;
	localparam int BIT_EGRESS_PRI = 0;
	localparam int BIT_DEFAULT_PRI = 4;
	localparam int BIT_TAG_EN = 5;
	localparam int BIT_CODE_POINT_EN = 6;
	localparam int BIT_FLOW_EN = 7;
	localparam logic [7:0] CTRL0_RESET = 8'h00;

	// limit index: 0 rx high, 1 rx low, 2 tx high, 3 tx low
	localparam int LIM_RX_HIGH = 0;
	localparam int LIM_RX_LOW = 1;
	localparam int LIM_TX_HIGH = 2;
	localparam int LIM_TX_LOW = 3;

	// ----------------------------------------------------------------
	// rate limiting
	// ----------------------------------------------------------------
	localparam int STEP_BPS = 32000;
	localparam int BYTES_PER_STEP = STEP_BPS / 8;
	localparam int FLOW_KBPS = 128;
	localparam logic [LIMIT_W-1:0] FLOW_STEPS = LIMIT_W'(FLOW_KBPS * 1000 / STEP_BPS);
	localparam logic [COUNT_W-1:0] MARGIN_BIG = 24'h002000;
	localparam logic [COUNT_W-1:0] MARGIN_SMALL = 24'h000800;

	localparam int CLK_KHZ = 100000;
	localparam int INTERVAL_MS = 1000;
	localparam int INTERVAL_CYCLES = CLK_KHZ * INTERVAL_MS;

	// ----------------------------------------------------------------
	// egress scheme
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCHEME_STRICT = 2'b00,
		SCHEME_TEN = 2'b01,
		SCHEME_FIVE = 2'b10,
		SCHEME_TWO = 2'b11
	} scheme_type;

	localparam logic [3:0] RATIO_TEN = 4'ha;
	localparam logic [3:0] RATIO_FIVE = 4'h5;
	localparam logic [3:0] RATIO_TWO = 4'h2;

endpackage

// *** qos_classify_rate_limit.sv ***
`timescale 1ns/1ps
// Functional notes
// - tagged packet with tag enable is high when user priority >= base priority
// - six-bit code point field indexes one of 64 map bits
// - entry n sits at bit n%8 of register 0x67 minus n/8
// - selected map bit 1 means high, 0 means low
// - code point classification only on ports with code point enable, IPv4 only
// - code point enable is bit 6 of port control 0, stride 16
// - classified packets go to high or low egress queue
// - egress priority disabled serves all packets as one priority
// - scheme 00 strict, 01 ten to one, 10 five to one, 11 two to one
// - rx and tx limits per port in 32 kbps steps
// - byte counters clear each second then count bytes
// - rx count above limit stops receive until interval ends
// - flow control within 8 KB of limit, 2 KB below 128 kbps
// - tx count above limit stops transmit until interval ends
// - priority enabled gives separate high and low limits
// - default priority bit overridden by OR of enabled tag and code point results
// - tag classification only on ports with bit 5 of control 0 set
module qos_classify_rate_limit #(
	parameter int NUM_PORTS = qos_pkg::NUM_PORTS,
	parameter int INTERVAL_CYCLES = qos_pkg::INTERVAL_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [6:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic classValid,
	input wire logic [2:0] classPort,
	input wire logic classTagged,
	input wire logic [2:0] classUserPri,
	input wire logic classIpv4,
	input wire logic [5:0] classCodePoint,
	output logic classDone,
	output logic classHigh,
	input wire logic [NUM_PORTS-1:0] rxPktDone,
	input wire logic [NUM_PORTS*qos_pkg::LEN_W-1:0] rxPktBytes,
	input wire logic [NUM_PORTS-1:0] rxPktHigh,
	output logic [NUM_PORTS-1:0] rxStopHigh,
	output logic [NUM_PORTS-1:0] rxStopLow,
	output logic [NUM_PORTS-1:0] rxFlowCtrl,
	input wire logic [NUM_PORTS-1:0] txPktDone,
	input wire logic [NUM_PORTS*qos_pkg::LEN_W-1:0] txPktBytes,
	input wire logic [NUM_PORTS-1:0] txPktHigh,
	output logic [NUM_PORTS-1:0] txStopHigh,
	output logic [NUM_PORTS-1:0] txStopLow,
	input wire logic [NUM_PORTS-1:0] qHighPending,
	input wire logic [NUM_PORTS-1:0] qLowPending,
	input wire logic [NUM_PORTS-1:0] txSlotReq,
	output logic [NUM_PORTS-1:0] serveHigh,
	output logic [NUM_PORTS-1:0] serveLow
);

	localparam int LW = qos_pkg::LIMIT_W;
	localparam int CW = qos_pkg::COUNT_W;
	localparam int NL = qos_pkg::NUM_LIMITS;

	// ----------------------------------------------------------------
	// global registers
	// ----------------------------------------------------------------
	logic [2:0] basePriority;
	qos_pkg::scheme_type scheme;
	logic [63:0] codePointPriorityBits;
	logic [7:0] ctrl0 [NUM_PORTS];
	logic [7:0] limLow [NUM_PORTS][NL];
	logic [3:0] limHigh [NUM_PORTS][NL];
	logic flowEn [NUM_PORTS][2];
	logic [CW-1:0] byteCount [NUM_PORTS][NL];
	logic stopFlag [NUM_PORTS][NL];
	logic flowFlag [NUM_PORTS][2];
	logic [7:0] next_rdData;
	logic intervalTick;
	logic [31:0] intervalCount;

	always_ff @(posedge mclk) begin
		if (reset) begin
			basePriority <= qos_pkg::BASE_PRI_RESET;
			scheme <= qos_pkg::SCHEME_STRICT;
		end else if (regWrite) begin
			if (regAddr == qos_pkg::BASE_PRI_ADDR) begin
				basePriority <= regWrData[qos_pkg::BASE_PRI_LSB +: 3];
			end
			if (regAddr == qos_pkg::SCHEME_ADDR) begin
				scheme <= qos_pkg::scheme_type'(regWrData[qos_pkg::SCHEME_LSB +: 2]);
			end
		end
	end

	// ----------------------------------------------------------------
	// code point map
	// ----------------------------------------------------------------
	for (genvar r = 0; r < qos_pkg::MAP_REGS; r++) begin : g_map
		localparam logic [6:0] MAP_ADDR = 7'(qos_pkg::MAP_LAST_ADDR - 7'(r));
		always_ff @(posedge mclk) begin
			if (reset) begin
				codePointPriorityBits[r*8 +: 8] <= 8'h00;
			end else if (regWrite && regAddr == MAP_ADDR) begin
				codePointPriorityBits[r*8 +: 8] <= regWrData;
			end
		end
	end

	// ----------------------------------------------------------------
	// per port registers
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_portReg
		localparam logic [6:0] PA = 7'(qos_pkg::PORT_BASE + 7'(p) * qos_pkg::PORT_STRIDE);
		always_ff @(posedge mclk) begin
			if (reset) begin
				ctrl0[p] <= qos_pkg::CTRL0_RESET;
			end else if (regWrite && regAddr == 7'(PA + qos_pkg::CTRL0_OFS)) begin
				ctrl0[p] <= regWrData;
			end
		end
		for (genvar k = 0; k < NL; k++) begin : g_lim
			localparam logic [6:0] LA = 7'(PA + qos_pkg::LIMIT_OFS + 7'(2 * k));
			always_ff @(posedge mclk) begin
				if (reset) begin
					limLow[p][k] <= 8'h00;
					limHigh[p][k] <= 4'h0;
				end else if (regWrite && regAddr == LA) begin
					limLow[p][k] <= regWrData;
				end else if (regWrite && regAddr == 7'(LA + 7'h01)) begin
					limHigh[p][k] <= regWrData[3:0];
				end
			end
		end
		for (genvar k = 0; k < 2; k++) begin : g_flow
			localparam logic [6:0] FA = 7'(PA + qos_pkg::LIMIT_OFS + 7'(2 * k + 1));
			always_ff @(posedge mclk) begin
				if (reset) begin
					flowEn[p][k] <= 1'b0;
				end else if (regWrite && regAddr == FA) begin
					flowEn[p][k] <= regWrData[qos_pkg::BIT_FLOW_EN];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_comb begin
		logic [6:0] pa;
		logic [6:0] la;
		next_rdData = 8'h00;
		pa = 7'h00;
		la = 7'h00;
		if (regAddr == qos_pkg::BASE_PRI_ADDR) begin
			next_rdData[qos_pkg::BASE_PRI_LSB +: 3] = basePriority;
		end
		if (regAddr == qos_pkg::SCHEME_ADDR) begin
			next_rdData[qos_pkg::SCHEME_LSB +: 2] = scheme;
		end
		for (int r = 0; r < qos_pkg::MAP_REGS; r++) begin
			if (regAddr == 7'(qos_pkg::MAP_LAST_ADDR - 7'(r))) begin
				next_rdData = codePointPriorityBits[r*8 +: 8];
			end
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			pa = 7'(qos_pkg::PORT_BASE + 7'(p) * qos_pkg::PORT_STRIDE);
			if (regAddr == 7'(pa + qos_pkg::CTRL0_OFS)) begin
				next_rdData = ctrl0[p];
			end
			for (int k = 0; k < NL; k++) begin
				la = 7'(pa + qos_pkg::LIMIT_OFS + 7'(2 * k));
				if (regAddr == la) begin
					next_rdData = limLow[p][k];
				end
				if (regAddr == 7'(la + 7'h01)) begin
					next_rdData = {(k < 2) ? flowEn[p][k % 2] : 1'b0, 3'h0, limHigh[p][k]};
				end
			end
			if (regAddr == 7'(pa + qos_pkg::STATUS_OFS)) begin
				next_rdData = {1'b0, rxFlowCtrl[p], txStopLow[p], txStopHigh[p],
					2'b00, rxStopLow[p], rxStopHigh[p]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= next_rdData;
		end
	end

	// ----------------------------------------------------------------
	// ingress classification
	// ----------------------------------------------------------------
	logic [7:0] classCtrl;
	logic tagUse;
	logic codeUse;
	logic tagHigh;
	logic codeHigh;

	always_comb begin
		classCtrl = 8'h00;
		if (classPort < 3'(NUM_PORTS)) begin
			classCtrl = ctrl0[classPort];
		end
		tagUse = classCtrl[qos_pkg::BIT_TAG_EN] && classTagged;
		codeUse = classCtrl[qos_pkg::BIT_CODE_POINT_EN] && classIpv4;
		tagHigh = tagUse && (classUserPri >= basePriority);
		codeHigh = codeUse && codePointPriorityBits[classCodePoint];
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			classDone <= 1'b0;
			classHigh <= 1'b0;
		end else begin
			classDone <= classValid;
			if (classValid) begin
				if (tagUse || codeUse) begin
					classHigh <= tagHigh || codeHigh;
				end else begin
					classHigh <= classCtrl[qos_pkg::BIT_DEFAULT_PRI];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// one second interval
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			intervalCount <= 32'h00000000;
			intervalTick <= 1'b0;
		end else if (intervalCount == 32'(INTERVAL_CYCLES - 1)) begin
			intervalCount <= 32'h00000000;
			intervalTick <= 1'b1;
		end else begin
			intervalCount <= intervalCount + 32'h00000001;
			intervalTick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// byte counters and limits
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rate
		logic prioEn;
		assign prioEn = ctrl0[p][qos_pkg::BIT_EGRESS_PRI];
		for (genvar k = 0; k < NL; k++) begin : g_cnt
			logic done;
			logic pktHigh;
			logic mine;
			logic [LW-1:0] limSteps;
			logic [CW-1:0] limBytes;
			logic [CW-1:0] bytes;
			logic [CW:0] sum;
			assign done = (k < 2) ? rxPktDone[p] : txPktDone[p];
			assign pktHigh = (k < 2) ? rxPktHigh[p] : txPktHigh[p];
			assign bytes = CW'((k < 2) ? rxPktBytes[p*qos_pkg::LEN_W +: qos_pkg::LEN_W]
				: txPktBytes[p*qos_pkg::LEN_W +: qos_pkg::LEN_W]);
			// without priority every packet is counted on the low limit
			assign mine = done && (((k % 2) == 0) == (prioEn && pktHigh));
			assign limSteps = {limHigh[p][k], limLow[p][k]};
			assign limBytes = CW'(limSteps) * CW'(qos_pkg::BYTES_PER_STEP);
			assign sum = {1'b0, byteCount[p][k]} + {1'b0, bytes};
			always_ff @(posedge mclk) begin
				if (reset) begin
					byteCount[p][k] <= '0;
				end else if (intervalTick) begin
					byteCount[p][k] <= mine ? bytes : '0;
				end else if (mine) begin
					byteCount[p][k] <= sum[CW] ? '1 : sum[CW-1:0];
				end
			end
			always_ff @(posedge mclk) begin
				if (reset || intervalTick) begin
					stopFlag[p][k] <= 1'b0;
				end else if (limSteps != '0 && byteCount[p][k] > limBytes) begin
					stopFlag[p][k] <= 1'b1;
				end
			end
			if (k < 2) begin : g_fc
				logic [CW-1:0] margin;
				logic [CW-1:0] thresh;
				assign margin = (limSteps >= qos_pkg::FLOW_STEPS) ? qos_pkg::MARGIN_BIG
					: qos_pkg::MARGIN_SMALL;
				assign thresh = (limBytes > margin) ? limBytes - margin : '0;
				always_ff @(posedge mclk) begin
					if (reset || intervalTick) begin
						flowFlag[p][k] <= 1'b0;
					end else if (flowEn[p][k] && limSteps != '0 && byteCount[p][k] >= thresh) begin
						flowFlag[p][k] <= 1'b1;
					end
				end
			end
		end
		assign rxStopLow[p] = stopFlag[p][qos_pkg::LIM_RX_LOW];
		assign rxStopHigh[p] = prioEn ? stopFlag[p][qos_pkg::LIM_RX_HIGH]
			: stopFlag[p][qos_pkg::LIM_RX_LOW];
		assign txStopLow[p] = stopFlag[p][qos_pkg::LIM_TX_LOW];
		assign txStopHigh[p] = prioEn ? stopFlag[p][qos_pkg::LIM_TX_HIGH]
			: stopFlag[p][qos_pkg::LIM_TX_LOW];
		assign rxFlowCtrl[p] = flowFlag[p][qos_pkg::LIM_RX_LOW]
			|| (prioEn && flowFlag[p][qos_pkg::LIM_RX_HIGH]);
	end

	// ----------------------------------------------------------------
	// egress scheduler
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sched
		logic [3:0] highRun;
		logic lastHigh;
		logic hiOk;
		logic loOk;
		logic [3:0] ratio;
		assign hiOk = qHighPending[p] && !txStopHigh[p];
		assign loOk = qLowPending[p] && !txStopLow[p];
		always_comb begin
			case (scheme)
				qos_pkg::SCHEME_TEN: ratio = qos_pkg::RATIO_TEN;
				qos_pkg::SCHEME_FIVE: ratio = qos_pkg::RATIO_FIVE;
				qos_pkg::SCHEME_TWO: ratio = qos_pkg::RATIO_TWO;
				default: ratio = 4'h0;
			endcase
		end
		always_ff @(posedge mclk) begin
			if (reset) begin
				serveHigh[p] <= 1'b0;
				serveLow[p] <= 1'b0;
				highRun <= 4'h0;
				lastHigh <= 1'b0;
			end else begin
				serveHigh[p] <= 1'b0;
				serveLow[p] <= 1'b0;
				if (txSlotReq[p] && (hiOk || loOk)) begin
					if (!ctrl0[p][qos_pkg::BIT_EGRESS_PRI]) begin
						// one priority: alternate when both wait
						if (hiOk && (!loOk || !lastHigh)) begin
							serveHigh[p] <= 1'b1;
							lastHigh <= 1'b1;
						end else begin
							serveLow[p] <= 1'b1;
							lastHigh <= 1'b0;
						end
					end else if (hiOk && !(loOk && ratio != 4'h0 && highRun >= ratio)) begin
						serveHigh[p] <= 1'b1;
						if (loOk) begin
							highRun <= highRun + 4'h1;
						end
					end else begin
						serveLow[p] <= 1'b1;
						highRun <= 4'h0;
					end
				end
			end
		end
	end

endmodule

// *** qos_checker_sva.sv ***
`timescale 1ns/1ps
module qos_checker #(
	parameter int NUM_PORTS = 5
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [6:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic classValid,
	input wire logic classDone,
	input wire logic classHigh,
	input wire logic [NUM_PORTS-1:0] rxPktDone,
	input wire logic [NUM_PORTS-1:0] txPktDone,
	input wire logic [NUM_PORTS-1:0] rxStopLow,
	input wire logic [NUM_PORTS-1:0] txStopLow,
	input wire logic [NUM_PORTS-1:0] qHighPending,
	input wire logic [NUM_PORTS-1:0] qLowPending,
	input wire logic [NUM_PORTS-1:0] txSlotReq,
	input wire logic [NUM_PORTS-1:0] serveHigh,
	input wire logic [NUM_PORTS-1:0] serveLow
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	a_done_follows_req: assert property (classValid |=> classDone)
		else $error("no result after request");
	a_no_stray_done: assert property (!classValid |=> !classDone)
		else $error("result without request");
	a_serve_needs_req: assert property (((serveHigh | serveLow) & ~$past(txSlotReq)) == '0)
		else $error("serve without request");
	a_serve_one_queue: assert property ((serveHigh & serveLow) == '0)
		else $error("both queues served");
	a_high_was_pending: assert property ((serveHigh & ~$past(qHighPending)) == '0)
		else $error("empty high queue served");
	a_low_was_pending: assert property ((serveLow & ~$past(qLowPending)) == '0)
		else $error("empty low queue served");
	a_map_read_back: assert property (regWrite && regAddr >= qos_pkg::MAP_FIRST_ADDR
		&& regAddr <= qos_pkg::MAP_LAST_ADDR ##1 !regWrite && $stable(regAddr)
		|=> regRdData == $past(regWrData, 2)) else $error("map entry not read back");
	a_base_reserved_zero: assert property (regAddr == qos_pkg::BASE_PRI_ADDR
		|=> regRdData[7] == 1'b0 && regRdData[3:0] == 4'h0) else $error("reserved bits set");
	a_rx_stop_cause: assert property (!$past(regWrite) && !$past(regWrite, 2)
		|-> (rxStopLow & ~$past(rxStopLow) & ~$past(rxPktDone, 2)) == '0)
		else $error("receive stop without packet");
	a_tx_stop_cause: assert property (!$past(regWrite) && !$past(regWrite, 2)
		|-> (txStopLow & ~$past(txStopLow) & ~$past(txPktDone, 2)) == '0)
		else $error("transmit stop without packet");
	c_class_high: cover property (classDone && classHigh);
	c_serve_low: cover property (serveLow != '0);
	c_rx_stop: cover property (rxStopLow != '0);
endmodule

bind qos_classify_rate_limit qos_checker #(.NUM_PORTS(NUM_PORTS)) chk (.mclk, .reset,
	.regAddr, .regWrite, .regWrData, .regRdData, .classValid, .classDone, .classHigh,
	.rxPktDone, .txPktDone, .rxStopLow, .txStopLow, .qHighPending, .qLowPending,
	.txSlotReq, .serveHigh, .serveLow);

// *** qos_queue_model.sv ***
`timescale 1ns/1ps
module qos_queue_model #(
	parameter int NUM_PORTS = 5
) (
	input wire logic mclk,
	input wire logic [NUM_PORTS-1:0] serveHigh,
	input wire logic [NUM_PORTS-1:0] serveLow,
	output logic [NUM_PORTS-1:0] qHighPending,
	output logic [NUM_PORTS-1:0] qLowPending
);
	int hiCnt [NUM_PORTS];
	int loCnt [NUM_PORTS];
	// packets leave a queue when taken
	always @(posedge mclk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			hiCnt[p] -= int'(serveHigh[p]);
			loCnt[p] -= int'(serveLow[p]);
		end
	end
	// pending drops as soon as a take shows
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			qHighPending[p] = hiCnt[p] > int'(serveHigh[p]);
			qLowPending[p] = loCnt[p] > int'(serveLow[p]);
		end
	end
	task automatic load(input int p, input int h, input int l);
		hiCnt[p] = h;
		loCnt[p] = l;
	endtask
endmodule

// *** tb_qos_classify_rate_limit.sv ***
`timescale 1ns/1ps
module tb_qos_classify_rate_limit;
	localparam int IVL = 2000;
	logic mclk = 0, reset = 1, regWrite = 0, classValid = 0, classTagged = 0, classIpv4 = 0;
	logic [6:0] regAddr = '0;
	logic [7:0] regWrData = '0, regRdData;
	logic [2:0] classPort = '0, classUserPri = '0, basePri;
	logic [5:0] classCodePoint = '0;
	logic classDone, classHigh;
	logic [4:0] rxPktDone = '0, rxPktHigh = '0, txPktDone = '0, txPktHigh = '0, txSlotReq = '0;
	logic [54:0] rxPktBytes = '0, txPktBytes = '0;
	logic [4:0] rxStopHigh, rxStopLow, rxFlowCtrl, txStopHigh, txStopLow;
	logic [4:0] qHighPending, qLowPending, serveHigh, serveLow;
	logic [7:0] ctl [5];
	logic [7:0] mapByte [8];
	int n_fail = 0, cmp_count = 0, cyc = 0;

	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc <= reset ? 0 : cyc + 1;

	qos_classify_rate_limit #(.INTERVAL_CYCLES(IVL)) DUT (.mclk, .reset, .regAddr, .regWrite,
		.regWrData, .regRdData, .classValid, .classPort, .classTagged, .classUserPri,
		.classIpv4, .classCodePoint, .classDone, .classHigh, .rxPktDone, .rxPktBytes,
		.rxPktHigh, .rxStopHigh, .rxStopLow, .rxFlowCtrl, .txPktDone, .txPktBytes,
		.txPktHigh, .txStopHigh, .txStopLow, .qHighPending, .qLowPending, .txSlotReq,
		.serveHigh, .serveLow);
	qos_queue_model Q (.mclk, .serveHigh, .serveLow, .qHighPending, .qLowPending);

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		{regAddr, regWrData, regWrite} <= {a, d, 1'b1};
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge mclk);
		regAddr <= a;
		@(posedge mclk);
		#1 chk("read data", e, regRdData);
	endtask
	function automatic logic ecls(int p, logic t, logic [2:0] u, logic v, logic [5:0] c);
		logic tg;
		logic cp;
		tg = ctl[p][5] & t;
		cp = ctl[p][6] & v;
		if (tg | cp) return (tg & (u >= basePri)) | (cp & mapByte[7 - c[5:3]][c[2:0]]);
		return ctl[p][4];
	endfunction
	task automatic cls();
		int p;
		logic t;
		logic v;
		logic [2:0] u;
		logic [5:0] c;
		p = $urandom_range(4);
		t = 1'($urandom);
		v = 1'($urandom);
		u = $urandom_range(2) == 0 ? basePri - 3'h1 : 3'($urandom);
		c = 6'($urandom);
		@(posedge mclk);
		{classValid, classPort, classTagged, classUserPri, classIpv4, classCodePoint} <=
			{1'b1, 3'(p), t, u, v, c};
		@(posedge mclk);
		classValid <= 1'b0;
		#1 chk("class done", 1, classDone);
		chk("class high", ecls(p, t, u, v, c), classHigh);
	endtask
	task automatic sched(input int p, input int s, input int h, input int l);
		int run;
		logic [1:0] ex;
		logic [1:0] last;
		run = 0;
		last = 2'b00;
		Q.load(p, h, l);
		for (int k = 0; k <= 15; k++) begin
			if (h == 0 && l == 0) ex = 2'b00;
			else if (l == 0 || (h > 0 && s == 0)) ex = 2'b10;
			else if (h == 0 || (s < 4 && run == (s == 1 ? 10 : s == 2 ? 5 : 2))) ex = 2'b01;
			else if (s == 4) ex = last[1] ? 2'b01 : 2'b10;
			else ex = 2'b10;
			@(posedge mclk);
			txSlotReq[p] <= 1'b1;
			@(posedge mclk);
			txSlotReq[p] <= 1'b0;
			#1;
			chk("serve", ex, {serveHigh[p], serveLow[p]});
			last = {serveHigh[p], serveLow[p]};
			run = ex == 2'b01 ? 0 : run + int'(ex[1] && l > 0);
			h -= int'(last[1]);
			l -= int'(last[0]);
		end
	endtask
	task automatic rate(input bit rx, input int p, input bit ph, input bit lh, input int st);
		int cnt;
		int lim;
		int thr;
		int a;
		logic [4:0] so;
		cnt = 0;
		lim = st * 4000;
		thr = lim - (st >= 4 ? 8192 : 2048);
		a = 16 * p + 21 + (rx ? 0 : 4) + (lh ? 0 : 2);
		wr(7'(a), 8'(st));
		wr(7'(a + 1), 8'h80 | 8'(st >> 8));
		while (cyc % IVL != 20) @(posedge mclk);
		repeat (17) begin
			cnt += 1000;
			@(posedge mclk);
			if (rx) {rxPktDone[p], rxPktHigh[p], rxPktBytes[11*p+:11]} <= {1'b1, ph, 11'h3e8};
			else {txPktDone[p], txPktHigh[p], txPktBytes[11*p+:11]} <= {1'b1, ph, 11'h3e8};
			@(posedge mclk);
			{rxPktDone, txPktDone} <= '0;
			@(posedge mclk);
			#1 so = rx ? (lh ? rxStopHigh : rxStopLow) : (lh ? txStopHigh : txStopLow);
			chk("stop", cnt > lim, so[p]);
			if (rx) chk("flow", cnt >= thr, rxFlowCtrl[p]);
			if (rx) chk("stop high", cnt > lim, rxStopHigh[p]);
			else chk("other class", 0, txStopLow[p]);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		#400000;
		n_fail++;
		results();
	end
	initial begin
		void'($urandom(60352));
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		rd(7'h02, 8'h40);
		rd(7'h05, 8'h00);
		rd(7'h10, 8'h00);
		for (int i = 0; i < 8; i++) rd(7'h60 + 7'(i), 8'h00);
		wr(7'h02, 8'hff);
		rd(7'h02, 8'h70);
		wr(7'h05, 8'hff);
		rd(7'h05, 8'h0c);
		wr(7'h7e, 8'h5a);
		rd(7'h7e, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			mapByte[i] = 8'($urandom);
			wr(7'h60 + 7'(i), mapByte[i]);
			rd(7'h60 + 7'(i), mapByte[i]);
		end
		basePri = 3'($urandom);
		wr(7'h02, {1'b0, basePri, 4'h0});
		repeat (4) begin
			for (int p = 0; p < 5; p++) begin
				ctl[p] = 8'($urandom);
				wr(7'h10 + 7'(16 * p), ctl[p]);
				rd(7'h10 + 7'(16 * p), ctl[p]);
			end
			repeat (50) cls();
		end
		$display("test classify done");
		wr(7'h10, 8'h01);
		wr(7'h20, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(7'h05, 8'(s << 2));
			sched(0, s, 12, 3);
		end
		sched(1, 4, 3, 3);
		$display("test scheduler done");
		wr(7'h40, 8'h00);
		wr(7'h50, 8'h01);
		rate(1, 3, 1, 0, 1);
		rate(1, 1, 0, 0, 4);
		rate(0, 4, 1, 1, 1);
		while (cyc % IVL != 20) @(posedge mclk);
		#1 chk("stops cleared", 0, {rxStopLow, rxFlowCtrl, txStopHigh});
		$display("test rate done");
		results();
	end
endmodule
